// *** rtl/ocpwm_pkg.sv ***
// Package with register map, field positions and enumerations of the compare channel.
package ocpwm_pkg;

    // Register indices on the plain register port.
    localparam logic [2:0] OCPWM_ADDR_CTRL_ONE = 3'h0;
    localparam logic [2:0] OCPWM_ADDR_CTRL_TWO = 3'h1;
    localparam logic [2:0] OCPWM_ADDR_PRIMARY = 3'h2;
    localparam logic [2:0] OCPWM_ADDR_SECONDARY = 3'h3;
    localparam logic [2:0] OCPWM_ADDR_PERIOD = 3'h4;
    localparam logic [2:0] OCPWM_ADDR_COUNTER = 3'h5;

    // Control register one field positions.
    localparam int OCPWM_C1_IDLE_STOP = 13;
    localparam int OCPWM_C1_TSEL_LSB = 10;
    localparam int OCPWM_C1_FLT_EN = 7;
    localparam int OCPWM_C1_FLT_STAT = 4;
    localparam int OCPWM_C1_TRIG_MODE = 3;
    localparam logic [15:0] OCPWM_C1_WMASK = 16'h3C8F;

    // Control register two field positions.
    localparam int OCPWM_C2_FLT_MD = 15;
    localparam int OCPWM_C2_FLT_OUT = 14;
    localparam int OCPWM_C2_FLT_TRI = 13;
    localparam int OCPWM_C2_INV = 12;
    localparam int OCPWM_C2_CASCADE = 8;
    localparam int OCPWM_C2_TRIG_SEL = 7;
    localparam int OCPWM_C2_TRIG_STAT = 6;
    localparam int OCPWM_C2_TRIS = 5;
    localparam logic [15:0] OCPWM_C2_WMASK = 16'hF1FF;

    // Reset values.
    localparam logic [15:0] OCPWM_C1_RESET = 16'h0000;
    localparam logic [15:0] OCPWM_C2_RESET = 16'h000C;
    localparam logic [15:0] OCPWM_WORD_RESET = 16'h0000;

    // Time base selection codes.
    localparam logic [2:0] OCPWM_TSEL_T1 = 3'h4;
    localparam logic [2:0] OCPWM_TSEL_SYS = 3'h7;

    // Sync source codes.
    localparam logic [4:0] OCPWM_SYNC_NONE = 5'h00;
    localparam logic [4:0] OCPWM_SYNC_SELF = 5'h1F;

    // Waveform modes.
    typedef enum logic [2:0] {
        OCPWM_OFF = 3'h0,
        OCPWM_SGL_RISE = 3'h1,
        OCPWM_SGL_FALL = 3'h2,
        OCPWM_SGL_TOGGLE = 3'h3,
        OCPWM_DBL_SHOT = 3'h4,
        OCPWM_DBL_CONT = 3'h5,
        OCPWM_PWM_EDGE = 3'h6,
        OCPWM_PWM_CENTER = 3'h7
    } ocpwm_mode_t;

    // Time base event bundle: one tick input per selectable source.
    typedef struct packed {
        logic [4:0] tick;
        logic [4:0] period_match;
    } ocpwm_tbase_t;

    // Register port request.
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ocpwm_req_t;

endpackage : ocpwm_pkg

// *** rtl/ocpwm_channel.sv ***
// Output compare channel with single-shot, toggle and PWM waveforms, fault and trigger logic.
`timescale 1ns/1ps
module ocpwm_channel #(
    parameter int CHANNEL_INDEX = 1
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire ocpwm_pkg::ocpwm_req_t req_i,
    output logic [15:0] rdata_o,
    input wire ocpwm_pkg::ocpwm_tbase_t tbase_i,
    input wire logic cpu_idle_i,
    input wire logic fault_pin_a_i,
    input wire logic fault_pin_b_i,
    input wire logic [31:0] sync_event_i,
    input wire logic cascade_carry_i,
    output logic cascade_carry_o,
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe_n_o,
    output logic channel_interrupt_flag_o,
    output logic sync_event_o
);
    import ocpwm_pkg::*;

    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
    logic [15:0] primary_active;
    logic [15:0] secondary_active;
    logic [15:0] timer_period_value;
    logic [15:0] channel_counter;
    logic fault_status_flag;
    logic trigger_status;
    logic fault_active;
    logic out_level;
    logic shot_done;
    logic second_phase;
    logic tick;
    logic run;
    logic sync_hit;
    logic fault_in;
    logic primary_match;
    logic secondary_match;
    logic period_match;
    logic pwm_mode;
    logic next_out;
    ocpwm_mode_t mode;

    // Pick one bit out of a five-wide source bundle by time base code.
    function automatic logic ocpwm_pick(input logic [4:0] src, input logic [2:0] sel);
        logic r;
        r = 1'b0;
        if (sel < OCPWM_TSEL_T1) begin
            // Widened first so the last timer code does not wrap onto timer 1.
            r = src[{1'b0, sel[1:0]} + 3'd1];
        end else if (sel == OCPWM_TSEL_T1) begin
            r = src[0];
        end
        return r;
    endfunction : ocpwm_pick

    assign mode = ocpwm_mode_t'(ctrl_one[2:0]);
    assign pwm_mode = (mode == OCPWM_PWM_EDGE) || (mode == OCPWM_PWM_CENTER);

    // Time base tick; reserved codes never tick and the system clock ticks always.
    always_comb begin
        if (ctrl_one[OCPWM_C1_TSEL_LSB+:3] == OCPWM_TSEL_SYS) begin
            tick = 1'b1;
        end else begin
            tick = ocpwm_pick(tbase_i.tick, ctrl_one[OCPWM_C1_TSEL_LSB+:3]);
        end
    end

    // The channel freezes while idle if told to, so stopped state resumes intact.
    assign run = clk_en_i && !(cpu_idle_i && ctrl_one[OCPWM_C1_IDLE_STOP]);

    // Sync source decode; code zero means free-running, the top code is our own period.
    always_comb begin
        if (ctrl_two[4:0] == OCPWM_SYNC_NONE) begin
            sync_hit = 1'b0;
        end else if (ctrl_two[4:0] == OCPWM_SYNC_SELF) begin
            sync_hit = period_match;
        end else begin
            sync_hit = sync_event_i[ctrl_two[4:0]];
        end
    end

    // Fault pin routing follows the channel number.
    assign fault_in = ctrl_one[OCPWM_C1_FLT_EN] &&
        ((CHANNEL_INDEX <= 4) ? fault_pin_a_i : fault_pin_b_i);

    assign primary_match = tick && (channel_counter == primary_active);
    assign secondary_match = tick && (channel_counter == secondary_active);
    assign period_match = tick && (channel_counter == timer_period_value);

    // Channel counter: wraps after period value so a cycle is period plus one counts.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            channel_counter <= OCPWM_WORD_RESET;
        end else if (run) begin
            if (ctrl_two[OCPWM_C2_TRIG_SEL] && !trigger_status) begin
                channel_counter <= OCPWM_WORD_RESET;
            end else if (!ctrl_two[OCPWM_C2_TRIG_SEL] && sync_hit) begin
                channel_counter <= OCPWM_WORD_RESET;
            end else if (tick) begin
                if (channel_counter == timer_period_value) begin
                    channel_counter <= OCPWM_WORD_RESET;
                end else begin
                    channel_counter <= channel_counter + 16'h0001;
                end
            end
        end
    end

    // Cascade carry to the partner channel on wrap of the low half.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cascade_carry_o <= 1'b0;
        end else if (run) begin
            cascade_carry_o <= ctrl_two[OCPWM_C2_CASCADE] && period_match;
        end
    end

    // Active compare values: PWM loads at period end, other modes follow writes at once.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            primary_active <= OCPWM_WORD_RESET;
            secondary_active <= OCPWM_WORD_RESET;
        end else if (run) begin
            if (!pwm_mode || period_match) begin
                primary_active <= primary_compare_value;
                secondary_active <= secondary_compare_value;
            end
        end
    end

    // Trigger status: set by the trigger source, set wins over every clear.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trigger_status <= 1'b0;
        end else if (run) begin
            if (ctrl_two[OCPWM_C2_TRIG_SEL] && sync_hit && ctrl_two[4:0] != OCPWM_SYNC_SELF) begin
                trigger_status <= 1'b1;
            end else if (ctrl_one[OCPWM_C1_TRIG_MODE] && secondary_match) begin
                trigger_status <= 1'b0;
            end else if (req_i.wr && req_i.addr == OCPWM_ADDR_CTRL_TWO) begin
                trigger_status <= req_i.wdata[OCPWM_C2_TRIG_STAT];
            end
        end
    end

    // Fault status and fault hold; the cause keeps the flag set over any release.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_status_flag <= 1'b0;
            fault_active <= 1'b0;
        end else if (run) begin
            if (fault_in && mode == OCPWM_PWM_CENTER) begin
                fault_status_flag <= 1'b1;
                fault_active <= 1'b1;
            end else if (fault_active && !fault_in) begin
                if (ctrl_two[OCPWM_C2_FLT_MD]) begin
                    if (req_i.wr && req_i.addr == OCPWM_ADDR_CTRL_ONE &&
                        !req_i.wdata[OCPWM_C1_FLT_STAT]) begin
                        fault_status_flag <= 1'b0;
                        fault_active <= 1'b0;
                    end
                end else if (period_match) begin
                    fault_status_flag <= 1'b0;
                    fault_active <= 1'b0;
                end
            end
        end
    end

    // Waveform generator next state per mode.
    always_comb begin
        next_out = out_level;
        unique case (mode)
            OCPWM_OFF: next_out = 1'b0;
            OCPWM_SGL_RISE: next_out = (primary_match && !shot_done) ? 1'b1 : out_level;
            OCPWM_SGL_FALL: next_out = (primary_match && !shot_done) ? 1'b0 : out_level;
            OCPWM_SGL_TOGGLE: next_out = primary_match ? !out_level : out_level;
            OCPWM_DBL_SHOT, OCPWM_DBL_CONT: begin
                if (!second_phase && primary_match && !shot_done) begin
                    next_out = 1'b1;
                end else if (second_phase && secondary_match) begin
                    next_out = 1'b0;
                end
            end
            OCPWM_PWM_EDGE, OCPWM_PWM_CENTER: begin
                if (secondary_active > timer_period_value) begin
                    next_out = 1'b1;
                end else if (period_match && primary_active != secondary_active) begin
                    next_out = (primary_active == OCPWM_WORD_RESET);
                end else if (secondary_match) begin
                    next_out = 1'b0;
                end else if (primary_match && primary_active != secondary_active) begin
                    next_out = 1'b1;
                end
            end
        endcase
    end

    // Output level, phase and one-shot tracking; a mode write restarts single shots.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_level <= 1'b0;
            shot_done <= 1'b0;
            second_phase <= 1'b0;
        end else if (clk_en_i && req_i.wr && req_i.addr == OCPWM_ADDR_CTRL_ONE) begin
            out_level <= (req_i.wdata[2:0] == OCPWM_SGL_FALL);
            shot_done <= 1'b0;
            second_phase <= 1'b0;
        end else if (run) begin
            out_level <= next_out;
            if (mode == OCPWM_DBL_SHOT || mode == OCPWM_DBL_CONT) begin
                if (!second_phase && primary_match && !shot_done) begin
                    second_phase <= 1'b1;
                end else if (second_phase && secondary_match) begin
                    second_phase <= 1'b0;
                    shot_done <= (mode == OCPWM_DBL_SHOT);
                end
            end else if (primary_match && mode != OCPWM_SGL_TOGGLE) begin
                shot_done <= 1'b1;
            end
        end
    end

    // Pin drive with fault override, inversion and direction control.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_output_pin_o <= 1'b0;
            compare_output_pin_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            if (fault_active) begin
                compare_output_pin_o <= ctrl_two[OCPWM_C2_FLT_OUT];
            end else begin
                compare_output_pin_o <= out_level ^ ctrl_two[OCPWM_C2_INV];
            end
            compare_output_pin_oe_n_o <= ctrl_two[OCPWM_C2_TRIS] &&
                !(fault_active && ctrl_two[OCPWM_C2_FLT_TRI]);
        end
    end

    // Interrupt pulse and own sync event, one cycle each.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            channel_interrupt_flag_o <= 1'b0;
            sync_event_o <= 1'b0;
        end else if (clk_en_i) begin
            sync_event_o <= run && period_match;
            if (mode == OCPWM_DBL_SHOT || mode == OCPWM_DBL_CONT) begin
                channel_interrupt_flag_o <= run && second_phase && secondary_match;
            end else begin
                channel_interrupt_flag_o <= run && primary_match && mode != OCPWM_OFF;
            end
        end
    end

    // Register writes; software cannot set the hardware status bits of register one.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_one <= OCPWM_C1_RESET;
            ctrl_two <= OCPWM_C2_RESET;
            primary_compare_value <= OCPWM_WORD_RESET;
            secondary_compare_value <= OCPWM_WORD_RESET;
            timer_period_value <= OCPWM_WORD_RESET;
        end else if (clk_en_i && req_i.wr) begin
            unique case (req_i.addr)
                OCPWM_ADDR_CTRL_ONE: ctrl_one <= req_i.wdata & OCPWM_C1_WMASK;
                OCPWM_ADDR_CTRL_TWO: ctrl_two <= req_i.wdata & OCPWM_C2_WMASK;
                OCPWM_ADDR_PRIMARY: primary_compare_value <= req_i.wdata;
                OCPWM_ADDR_SECONDARY: secondary_compare_value <= req_i.wdata;
                OCPWM_ADDR_PERIOD: timer_period_value <= req_i.wdata;
                default: ctrl_one <= ctrl_one;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= OCPWM_WORD_RESET;
        end else if (clk_en_i) begin
            rdata_o <= OCPWM_WORD_RESET;
            if (req_i.rd) begin
                unique case (req_i.addr)
                    OCPWM_ADDR_CTRL_ONE: rdata_o <= ctrl_one |
                        (16'h0001 << OCPWM_C1_FLT_STAT) & {16{fault_status_flag}};
                    OCPWM_ADDR_CTRL_TWO: rdata_o <= ctrl_two & ~(16'h0001 << OCPWM_C2_TRIG_STAT) |
                        (16'h0001 << OCPWM_C2_TRIG_STAT) & {16{trigger_status}};
                    OCPWM_ADDR_PRIMARY: rdata_o <= primary_compare_value;
                    OCPWM_ADDR_SECONDARY: rdata_o <= secondary_compare_value;
                    OCPWM_ADDR_PERIOD: rdata_o <= timer_period_value;
                    OCPWM_ADDR_COUNTER: rdata_o <= channel_counter;
                    default: rdata_o <= OCPWM_WORD_RESET;
                endcase
            end
        end
    end

endmodule : ocpwm_channel

// *** tb/ocpwm_channel_monitor.sv ***
// Checker of the compare channel port behaviour.
`timescale 1ns/1ps
module ocpwm_channel_monitor
    import ocpwm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire ocpwm_req_t req_i,
    input wire logic [15:0] rdata_o,
    input wire logic cpu_idle_i,
    input wire logic fault_pin_a_i,
    input wire logic compare_output_pin_o,
    input wire logic compare_output_pin_oe_n_o,
    input wire logic channel_interrupt_flag_o,
    input wire logic sync_event_o
);
    logic [15:0] c1, c2, prim, sec, per, quiet, gap;
    logic gap_ok;
    wire we = req_i.wr && clk_en_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Shadow copies of software settings, kept apart so the design is never trusted.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c1 <= OCPWM_C1_RESET;
            c2 <= OCPWM_C2_RESET;
            prim <= 16'h0000;
            sec <= 16'h0000;
            per <= 16'h0000;
        end else if (we) begin
            case (req_i.addr)
                OCPWM_ADDR_CTRL_ONE: c1 <= req_i.wdata;
                OCPWM_ADDR_CTRL_TWO: c2 <= req_i.wdata;
                OCPWM_ADDR_PRIMARY: prim <= req_i.wdata;
                OCPWM_ADDR_SECONDARY: sec <= req_i.wdata;
                OCPWM_ADDR_PERIOD: per <= req_i.wdata;
                default: ;
            endcase
        end
    end
    // Quiet time since the last write and spacing of period events.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            quiet <= 16'h0000;
            gap <= 16'h0000;
            gap_ok <= 1'b0;
        end else begin
            quiet <= we ? 16'h0000 : (quiet == 16'hFFFF ? quiet : quiet + 16'h0001);
            gap <= sync_event_o ? 16'h0001 : gap + 16'h0001;
            gap_ok <= (sync_event_o || gap_ok) && !we && clk_en_i && !cpu_idle_i;
        end
    end
    property p_period;
        sync_event_o && gap_ok && c1[12:10] == OCPWM_TSEL_SYS |-> gap == per + 16'h0001;
    endproperty
    a_period: assert property (p_period) else $error("period length wrong");
    property p_rd_quiet;
        !$past(req_i.rd && clk_en_i) |-> rdata_o == 16'h0000;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
    property p_ctrl_one;
        req_i.rd && clk_en_i && req_i.addr == OCPWM_ADDR_CTRL_ONE && quiet > 16'h0001
            |=> (rdata_o & OCPWM_C1_WMASK) == (c1 & OCPWM_C1_WMASK);
    endproperty
    a_ctrl_one: assert property (p_ctrl_one) else $error("control one readback");
    property p_idle;
        c1[13] && quiet > 16'h0002 && cpu_idle_i && $past(cpu_idle_i) && $past(cpu_idle_i, 2)
            |-> !sync_event_o;
    endproperty
    a_idle: assert property (p_idle) else $error("ran while idle");
    property p_off;
        c1[2:0] == 3'h0 && quiet > 16'h0002 |-> !channel_interrupt_flag_o;
    endproperty
    a_off: assert property (p_off) else $error("flag while disabled");
    property p_zero;
        c1[2:1] == 2'b11 && prim == 16'h0000 && sec == 16'h0000 && per == 16'h0000
            && !c1[7] && quiet > 16'h0004 |-> compare_output_pin_o == c2[12];
    endproperty
    a_zero: assert property (p_zero) else $error("zero duty not low");
    property p_full;
        c1[2:0] == 3'h6 && sec > per && prim <= per && !c1[7]
            && quiet > (per << 1) + 16'h0004 |-> compare_output_pin_o == !c2[12];
    endproperty
    a_full: assert property (p_full) else $error("full duty not high");
    property p_fault;
        (c1[2:0] == 3'h7 && c1[7] && fault_pin_a_i && !c2[12])[*4]
            |-> compare_output_pin_o == c2[14] && (!c2[13] || !compare_output_pin_oe_n_o);
    endproperty
    a_fault: assert property (p_fault) else $error("fault level wrong");
    property p_tris;
        quiet > 16'h0003 && !c1[7] |-> compare_output_pin_oe_n_o == c2[5];
    endproperty
    a_tris: assert property (p_tris) else $error("pin direction wrong");
    c_sync: cover property (sync_event_o && gap_ok);
    c_fault: cover property (fault_pin_a_i && c1[7] && c1[2:0] == 3'h7);
    c_idle: cover property (cpu_idle_i && c1[13]);
endmodule : ocpwm_channel_monitor

bind ocpwm_channel ocpwm_channel_monitor u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .req_i(req_i), .rdata_o(rdata_o), .cpu_idle_i(cpu_idle_i),
    .fault_pin_a_i(fault_pin_a_i), .compare_output_pin_o(compare_output_pin_o),
    .compare_output_pin_oe_n_o(compare_output_pin_oe_n_o),
    .channel_interrupt_flag_o(channel_interrupt_flag_o), .sync_event_o(sync_event_o));

// *** tb/ocpwm_load.sv ***
// Model of the external load on the compare output pin.
`timescale 1ns/1ps
module ocpwm_load (
    input wire logic ref_clk_i,
    input wire logic clear_i,
    input wire logic pin_i,
    input wire logic pin_oe_n_i,
    output logic level_o,
    output int rises_o,
    output int gap_o
);
    int since;
    logic prev;
    // The load has a pull-down, so a released pin reads low.
    assign level_o = pin_oe_n_i ? 1'b0 : pin_i;
    // Rising edges and spacing of the last two rises; clear restarts a window.
    always @(posedge ref_clk_i) begin
        prev <= level_o;
        since <= since + 1;
        if (clear_i) begin
            rises_o <= 0;
            gap_o <= 0;
        end else if (level_o === 1'b1 && prev === 1'b0) begin
            rises_o <= rises_o + 1;
            gap_o <= since + 1;
            since <= 0;
        end
    end
endmodule : ocpwm_load

// *** tb/output_compare_pwm_channel_bench.sv ***
// Self-checking bench of the compare channel.
`timescale 1ns/1ps
module output_compare_pwm_channel_bench;
    import ocpwm_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic idle = 1'b0;
    logic flt_a = 1'b0;
    logic flt_b = 1'b0;
    logic clear = 1'b0;
    ocpwm_req_t req = '0;
    logic [15:0] rdata, got;
    logic pin, oe_n, irq, sync_o, level;
    int rises, gap, irqs, fail_count = 0, checked = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    ocpwm_channel #(.CHANNEL_INDEX(1)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i), .req_i(req), .rdata_o(rdata), .tbase_i('0), .cpu_idle_i(idle),
        .fault_pin_a_i(flt_a), .fault_pin_b_i(flt_b), .sync_event_i(32'h00000000),
        .cascade_carry_i(1'b0), .cascade_carry_o(), .compare_output_pin_o(pin),
        .compare_output_pin_oe_n_o(oe_n), .channel_interrupt_flag_o(irq), .sync_event_o(sync_o));
    ocpwm_load load (.ref_clk_i(ref_clk_i), .clear_i(clear), .pin_i(pin), .pin_oe_n_i(oe_n),
        .level_o(level), .rises_o(rises), .gap_o(gap));
    // Interrupt pulses in the current window.
    always @(posedge ref_clk_i) irqs <= clear ? 0 : irqs + int'(irq === 1'b1);
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    // Wait a window, optionally restarting the load counts first.
    task automatic run(input int n, input bit restart);
        @(posedge ref_clk_i);
        clear <= restart;
        @(posedge ref_clk_i);
        clear <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask : run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // A hung run still reaches the verdict.
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(OCPWM_ADDR_CTRL_TWO, got);
        cmp(got, OCPWM_C2_RESET);
        rd(3'h6, got);
        cmp(got, 16'h0000);
        wr(OCPWM_ADDR_CTRL_ONE, 16'hFFF8);
        rd(OCPWM_ADDR_CTRL_ONE, got);
        cmp(got, 16'h3C88);
        $display("test registers done");
        wr(OCPWM_ADDR_CTRL_TWO, 16'h0000);
        wr(OCPWM_ADDR_PERIOD, 16'h0007);
        wr(OCPWM_ADDR_SECONDARY, 16'h0004);
        wr(OCPWM_ADDR_CTRL_ONE, 16'h1C06);
        run(40, 1);
        cmp(16'(gap), 16'h0008);
        rd(OCPWM_ADDR_COUNTER, got);
        cmp({15'h0000, got < 16'h0008}, 16'h0001);
        wr(OCPWM_ADDR_SECONDARY, 16'h000C);
        run(16, 0);
        cmp({15'h0000, pin}, 16'h0001);
        // A reset in mid-run clears the counter, so a zero period cannot strand it high.
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        wr(OCPWM_ADDR_CTRL_TWO, 16'h0000);
        wr(OCPWM_ADDR_CTRL_ONE, 16'h1C06);
        run(16, 1);
        cmp(16'(rises), 16'h0000);
        wr(OCPWM_ADDR_CTRL_TWO, 16'h1000);
        run(8, 0);
        cmp({15'h0000, pin}, 16'h0001);
        wr(OCPWM_ADDR_CTRL_TWO, 16'h1020);
        run(4, 0);
        cmp({15'h0000, oe_n}, 16'h0001);
        cmp({15'h0000, level}, 16'h0000);
        $display("test pwm done");
        wr(OCPWM_ADDR_CTRL_TWO, 16'h0000);
        wr(OCPWM_ADDR_PERIOD, 16'h0007);
        wr(OCPWM_ADDR_SECONDARY, 16'h0004);
        wr(OCPWM_ADDR_CTRL_ONE, 16'h3C06);
        idle <= 1'b1;
        run(24, 1);
        cmp(16'(rises), 16'h0000);
        idle <= 1'b0;
        run(24, 1);
        cmp({15'h0000, rises > 1}, 16'h0001);
        clk_en_i <= 1'b0;
        run(24, 1);
        clk_en_i <= 1'b1;
        cmp(16'(rises), 16'h0000);
        $display("test idle done");
        wr(OCPWM_ADDR_CTRL_TWO, 16'h6020);
        wr(OCPWM_ADDR_CTRL_ONE, 16'h1C87);
        flt_b <= 1'b1;
        run(24, 1);
        rd(OCPWM_ADDR_CTRL_ONE, got);
        cmp(got & 16'h0010, 16'h0000);
        flt_a <= 1'b1;
        run(8, 0);
        cmp({15'h0000, pin, oe_n}, 16'h0002);
        rd(OCPWM_ADDR_CTRL_ONE, got);
        cmp(got & 16'h0010, 16'h0010);
        flt_a <= 1'b0;
        flt_b <= 1'b0;
        run(24, 0);
        wr(OCPWM_ADDR_CTRL_TWO, 16'h0000);
        run(24, 1);
        cmp({15'h0000, rises > 0}, 16'h0001);
        wr(OCPWM_ADDR_CTRL_ONE, 16'h1C07);
        flt_a <= 1'b1;
        run(24, 1);
        flt_a <= 1'b0;
        cmp({15'h0000, rises > 0}, 16'h0001);
        $display("test fault done");
        wr(OCPWM_ADDR_PRIMARY, 16'h0003);
        wr(OCPWM_ADDR_SECONDARY, 16'h0005);
        for (int m = 1; m < 6; m++) begin
            wr(OCPWM_ADDR_CTRL_ONE, 16'h1C00);
            run(4, 1);
            wr(OCPWM_ADDR_CTRL_ONE, 16'h1C00 | 16'(m));
            run(40, 0);
            if (m == 3 || m == 5) begin
                cmp({14'h0000, rises > 1, irqs > 1}, 16'h0003);
            end else begin
                // Single compare modes flag every primary match; double shot flags once.
                cmp({14'h0000, rises == 1, (m == 4) ? irqs == 1 : irqs > 1}, 16'h0003);
                cmp({15'h0000, pin}, {15'h0000, m == 1});
            end
        end
        $display("test compare modes done");
        wr(OCPWM_ADDR_CTRL_TWO, 16'h0081);
        run(8, 0);
        rd(OCPWM_ADDR_COUNTER, got);
        cmp(got, 16'h0000);
        wr(OCPWM_ADDR_CTRL_TWO, 16'h00C1);
        run(24, 1);
        cmp({15'h0000, rises > 0}, 16'h0001);
        rd(OCPWM_ADDR_CTRL_TWO, got);
        cmp(got & 16'h0040, 16'h0040);
        wr(OCPWM_ADDR_CTRL_ONE, 16'h1C0D);
        run(16, 0);
        rd(OCPWM_ADDR_CTRL_TWO, got);
        cmp(got & 16'h0040, 16'h0000);
        $display("test trigger done");
        finish_test();
    end
endmodule : output_compare_pwm_channel_bench
